// ---- verilog/ttc_consts.svh ----
// Constants for the terminal transmission control block
`ifndef TTC_CONSTS_SVH
`define TTC_CONSTS_SVH
`define TTC_CLK_HZ 25000000
`define TTC_RATE_0 110
`define TTC_RATE_1 150
`define TTC_RATE_2 200
`define TTC_RATE_3 300
`define TTC_RATE_4 600
`define TTC_RATE_5 1200
`define TTC_RATE_6 1800
`define TTC_RATE_7 2400
`define TTC_RATE_8 4800
`define TTC_RATE_9 9600
`define TTC_RATE_CENTER_IDX 4'h3
`define TTC_FRAME_BITS 4'h9
`define TTC_REG_CFG 4'h0
`define TTC_REG_STAT 4'h4
`define TTC_CFG_RESET 12'hF09
`define TTC_CFG_HI_LSB 0
`define TTC_CFG_LO_LSB 4
`define TTC_CFG_MARK 8
`define TTC_CFG_TERM_ETX 9
`define TTC_CFG_TERM_EOT 10
`define TTC_CFG_SEND_TERM 11
`define TTC_STAT_PERR 4
`define TTC_SW_RESET 12'h400
`define TTC_SW_ONLINE 0
`define TTC_SW_FULL 1
`define TTC_SW_C64 2
`define TTC_SW_RATE_LSB 3
`define TTC_SW_MODE_LSB 5
`define TTC_SW_PAR_LSB 7
`define TTC_SW_FORMAT 9
`define TTC_SW_RXD 10
`define TTC_SW_CTS 11
`define TTC_CH_STX 7'h02
`define TTC_CH_ETX 7'h03
`define TTC_CH_EOT 7'h04
`define TTC_CH_BS 7'h08
`define TTC_CH_LF 7'h0A
`define TTC_CH_CLR 7'h0C
`define TTC_CH_CR 7'h0D
`define TTC_CH_DEL 7'h7F
`define TTC_LC_FIRST 7'h60
`define TTC_LC_LAST 7'h7E
`define TTC_ALPHA_FIRST 7'h61
`define TTC_ALPHA_LAST 7'h7A
`define TTC_CASE_OFFSET 7'h20
`endif

// ---- verilog/ttc_pkg.sv ----
// Types for the terminal transmission control block
package ttc_pkg;
  typedef enum logic [2:0] {
    TTC_SC_IDLE = 3'b000,
    TTC_SC_BRD = 3'b001,
    TTC_SC_BW = 3'b010,
    TTC_SC_BCHK = 3'b011,
    TTC_SC_FRD = 3'b100,
    TTC_SC_FW = 3'b101,
    TTC_SC_FCHK = 3'b110,
    TTC_SC_SEND = 3'b111
  } ttc_scan_t;
  typedef enum logic [1:0] {
    TTC_MODE_CHAR = 2'b00,
    TTC_MODE_LINE = 2'b01,
    TTC_MODE_BLOCK = 2'b10
  } ttc_mode_t;
  typedef enum logic [1:0] {
    TTC_PAR_NONE = 2'b00,
    TTC_PAR_EVEN = 2'b01,
    TTC_PAR_ODD = 2'b10
  } ttc_par_t;
  typedef enum logic [1:0] {
    TTC_RATE_CENTER = 2'b00,
    TTC_RATE_HIGH = 2'b01,
    TTC_RATE_LOW = 2'b10
  } ttc_rate_t;
endpackage

// ---- verilog/ttc_top.sv ----
// Keyboard routing, line/block transmission and serial modem link of the terminal
//
// Functional notes
// - Reset clears state; settings follow the synchronised switch positions from then on.
// - Local setting disables transmitter; keyboard characters go straight to display memory.
// - Character mode half duplex: each key goes to link and display memory.
// - Full duplex: keys go to link only; applies in character mode only.
// - 64-character setting drops codes 140-176 octal; lowercase letters become uppercase.
// - Centre position gives 300 baud; high/low use presets, default 9600/110.
// - Character mode sends one framed character per key via a three-entry buffer.
// - Line mode stores keys; entering carriage return starts transmission.
// - Line send runs from line start through first return, then cursor to line start.
// - Received characters dropped during line send; received break aborts at cursor.
// - Keyboard locked and lock lamp lit during a line send.
// - Block mode stores keys; send key transmits from previous STX to terminator.
// - Configuration selects ETX, EOT or both as block terminator.
// - Without a preceding STX, block send starts at first page position.
// - STX found after the start is sent as ordinary data.
// - No terminator: stop at last page position, cursor left there, no scroll.
// - Keyboard locked during block send; configuration decides if terminator is sent.
// - Block mode: control with backspace, clear or line feed stores code and advances.
// - Even/odd parity generated and checked; with none, mark/space bit fixes level.
// - Parity error stored as all-dots code 177 octal; no check for mark/space.
// - Format switch locks keyboard and lights lock lamp until returned.
// - Alert lamp lights on any received break.
// - Space in tenth bit is break; locks keyboard, lights alert and lock lamps.
// - No transmission starts while clear-to-send is absent.
`timescale 1ns/1ns
`include "ttc_consts.svh"
module ttc_top #(
  parameter int CLK_HZ = `TTC_CLK_HZ,
  parameter int COLS = 80,
  parameter int ROWS = 24,
  parameter int ADDR_W = 11
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic online_in,
  input wire logic echo_routing_select_in,
  input wire logic char64_in,
  input wire logic [1:0] rate_select_in,
  input wire logic [1:0] mode_select_in,
  input wire logic [1:0] parity_select_in,
  input wire logic format_in,
  input wire logic rxd_in,
  input wire logic cts_in,
  input wire logic kbd_strobe_in,
  input wire logic [6:0] kbd_code_in,
  input wire logic kbd_ctrl_in,
  input wire logic send_key_in,
  input wire logic break_key_in,
  input wire logic [6:0] mem_rdata_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [6:0] mem_wdata_out,
  output logic mem_we_out,
  output logic mem_rd_out,
  output logic txd_out,
  output logic rts_out,
  output logic kbd_lock_lamp_out,
  output logic alert_lamp_out,
  output logic [31:0] reg_rdata_out
);
  import ttc_pkg::*;

  localparam int CW = $clog2(COLS);
  localparam logic [ADDR_W-1:0] LAST = ADDR_W'(COLS * ROWS - 1);

  typedef struct packed {
    logic [11:0] sw1;
    logic [11:0] sw2;
    logic rx_prev;
    logic [2:0][6:0] fifo;
    logic [1:0] f_cnt;
    logic tx_busy;
    logic [8:0] tx_sh;
    logic [3:0] tx_n;
    logic [23:0] tx_cnt;
    logic rx_busy;
    logic [8:0] rx_sh;
    logic [3:0] rx_n;
    logic [23:0] rx_cnt;
    logic rx_pend;
    logic [6:0] rx_char;
    ttc_scan_t sc;
    logic [ADDR_W-1:0] pos;
    logic [ADDR_W-1:0] sc_start;
    logic [6:0] sc_char;
    logic sc_last;
    logic sc_pgend;
    logic [ADDR_W-1:0] cur;
    logic [CW-1:0] col;
    logic brk_lock;
    logic perr;
    logic [11:0] cfg;
    logic [ADDR_W-1:0] mem_addr;
    logic [6:0] mem_wdata;
    logic mem_we;
    logic mem_rd;
    logic txd;
    logic rts;
    logic lock_lamp;
    logic alert;
    logic [31:0] rdata;
  } ttc_state_t;

  ttc_state_t s;
  ttc_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] rate_div(input logic [3:0] idx);
    int r;
    case (idx)
      4'h0: r = `TTC_RATE_0;
      4'h1: r = `TTC_RATE_1;
      4'h2: r = `TTC_RATE_2;
      4'h3: r = `TTC_RATE_3;
      4'h4: r = `TTC_RATE_4;
      4'h5: r = `TTC_RATE_5;
      4'h6: r = `TTC_RATE_6;
      4'h7: r = `TTC_RATE_7;
      4'h8: r = `TTC_RATE_8;
      4'h9: r = `TTC_RATE_9;
      default: r = `TTC_RATE_3;
    endcase
    return 24'(CLK_HZ / r - 1);
  endfunction

  function automatic logic par_bit(input logic [6:0] d, input ttc_par_t p, input logic mark);
    case (p)
      TTC_PAR_EVEN: return ^d;
      TTC_PAR_ODD: return ~^d;
      default: return mark;
    endcase
  endfunction

  function automatic logic [CW-1:0] col_of(input logic [ADDR_W-1:0] a);
    return CW'(a % COLS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic online;
    logic full;
    logic c64;
    logic fmt;
    logic rxs;
    logic cts;
    ttc_mode_t mode;
    ttc_par_t par;
    ttc_rate_t rsel;
    logic [3:0] ridx;
    logic [23:0] div;
    logic lock;
    logic [6:0] c;
    logic take;
    logic kvalid;
    logic kfunc;
    logic kwrite;
    logic [6:0] src;
    logic src_ok;
    logic [1:0] cnt_after;
    logic [8:0] rx_new;
    logic term;
    logic finish;
    logic perr_new;
    next_s = s;
    next_s.mem_we = 1'b0;
    next_s.mem_rd = 1'b0;
    next_s.rdata = 32'h0000_0000;
    // Switches and modem lines are asynchronous pins
    next_s.sw1 = {cts_in, rxd_in, format_in, parity_select_in, mode_select_in, rate_select_in,
                  char64_in, echo_routing_select_in, online_in};
    next_s.sw2 = s.sw1;
    online = s.sw2[`TTC_SW_ONLINE];
    full = s.sw2[`TTC_SW_FULL];
    c64 = s.sw2[`TTC_SW_C64];
    fmt = s.sw2[`TTC_SW_FORMAT];
    rxs = s.sw2[`TTC_SW_RXD];
    cts = s.sw2[`TTC_SW_CTS];
    mode = ttc_mode_t'(s.sw2[`TTC_SW_MODE_LSB +: 2]);
    par = ttc_par_t'(s.sw2[`TTC_SW_PAR_LSB +: 2]);
    rsel = ttc_rate_t'(s.sw2[`TTC_SW_RATE_LSB +: 2]);
    next_s.rx_prev = rxs;
    case (rsel)
      TTC_RATE_HIGH: ridx = s.cfg[`TTC_CFG_HI_LSB +: 4];
      TTC_RATE_LOW: ridx = s.cfg[`TTC_CFG_LO_LSB +: 4];
      default: ridx = `TTC_RATE_CENTER_IDX;
    endcase
    div = rate_div(ridx);
    lock = s.brk_lock | fmt | (s.sc != TTC_SC_IDLE);
    term = 1'b0;
    finish = 1'b0;
    perr_new = 1'b0;

    // Transmit source: memory scan has priority, else the character buffer
    src_ok = (s.sc == TTC_SC_SEND) | ((s.f_cnt != 2'b00) & (s.sc == TTC_SC_IDLE));
    src = (s.sc == TTC_SC_SEND) ? s.sc_char : s.fifo[0];
    take = src_ok & ~s.tx_busy & cts & online;
    next_s.rts = online;

    // Transmitter
    if (take) begin
      next_s.tx_busy = 1'b1;
      next_s.txd = 1'b0;
      next_s.tx_sh = {1'b1, par_bit(src, par, s.cfg[`TTC_CFG_MARK]), src};
      next_s.tx_n = `TTC_FRAME_BITS;
      next_s.tx_cnt = div;
    end else if (s.tx_busy) begin
      if (s.tx_cnt != 24'h00_0000) begin
        next_s.tx_cnt = s.tx_cnt - 24'h00_0001;
      end else if (s.tx_n == 4'h0) begin
        next_s.tx_busy = 1'b0;
      end else begin
        next_s.txd = s.tx_sh[0];
        next_s.tx_sh = {1'b1, s.tx_sh[8:1]};
        next_s.tx_n = s.tx_n - 4'h1;
        next_s.tx_cnt = div;
      end
    end

    // Character buffer pop, then push further below
    cnt_after = s.f_cnt;
    if (take && s.sc == TTC_SC_IDLE) begin
      next_s.fifo = {7'h00, s.fifo[2], s.fifo[1]};
      cnt_after = s.f_cnt - 2'b01;
    end
    next_s.f_cnt = cnt_after;

    // Receiver, mid-bit sampling
    rx_new = {rxs, s.rx_sh[8:1]};
    if (!s.rx_busy) begin
      if (s.rx_prev && !rxs && online) begin
        next_s.rx_busy = 1'b1;
        next_s.rx_cnt = div >> 1;
        next_s.rx_n = 4'hA;
      end
    end else if (s.rx_cnt != 24'h00_0000) begin
      next_s.rx_cnt = s.rx_cnt - 24'h00_0001;
    end else if (s.rx_n == 4'hA) begin
      next_s.rx_busy = ~rxs;
      next_s.rx_n = `TTC_FRAME_BITS;
      next_s.rx_cnt = div;
    end else begin
      next_s.rx_sh = rx_new;
      next_s.rx_n = s.rx_n - 4'h1;
      next_s.rx_cnt = div;
      if (s.rx_n == 4'h1) begin
        next_s.rx_busy = 1'b0;
        if (!rx_new[8]) begin
          next_s.brk_lock = 1'b1;
          next_s.alert = 1'b1;
          if (s.sc != TTC_SC_IDLE) begin
            next_s.sc = TTC_SC_IDLE;
            next_s.cur = s.pos;
            next_s.col = col_of(s.pos);
          end
        end else if (s.sc == TTC_SC_IDLE) begin
          next_s.rx_pend = 1'b1;
          next_s.rx_char = rx_new[6:0];
          if (par != TTC_PAR_NONE && rx_new[7] != par_bit(rx_new[6:0], par, 1'b0)) begin
            next_s.rx_char = `TTC_CH_DEL;
            next_s.perr = 1'b1;
            perr_new = 1'b1;
          end
        end
      end
    end
    if (break_key_in) begin
      next_s.brk_lock = 1'b0;
      next_s.alert = 1'b0;
    end

    // Keyboard
    c = kbd_code_in;
    kvalid = kbd_strobe_in & ~lock;
    if (c64 && c >= `TTC_LC_FIRST && c <= `TTC_LC_LAST) begin
      if (c >= `TTC_ALPHA_FIRST && c <= `TTC_ALPHA_LAST) begin
        c = c - `TTC_CASE_OFFSET;
      end else begin
        kvalid = 1'b0;
      end
    end
    kfunc = (c == `TTC_CH_BS || c == `TTC_CH_LF || c == `TTC_CH_CLR) &&
            !(mode == TTC_MODE_BLOCK && kbd_ctrl_in);
    kwrite = 1'b0;
    if (kvalid && kfunc) begin
      if (c == `TTC_CH_BS && s.col != '0) begin
        next_s.cur = s.cur - 1'b1;
        next_s.col = s.col - 1'b1;
      end else if (c == `TTC_CH_LF && s.cur <= LAST - ADDR_W'(COLS)) begin
        next_s.cur = s.cur + ADDR_W'(COLS);
      end else if (c == `TTC_CH_CLR) begin
        next_s.cur = '0;
        next_s.col = '0;
      end
    end else if (kvalid) begin
      if (!online) begin
        kwrite = 1'b1;
      end else begin
        case (mode)
          TTC_MODE_CHAR: begin
            if (cnt_after != 2'b11) begin
              next_s.fifo[cnt_after] = c;
              next_s.f_cnt = cnt_after + 2'b01;
            end
            kwrite = ~full;
          end
          TTC_MODE_LINE: begin
            kwrite = 1'b1;
            if (c == `TTC_CH_CR) begin
              next_s.sc = TTC_SC_FRD;
              next_s.pos = s.cur - ADDR_W'(s.col);
              next_s.sc_start = s.cur - ADDR_W'(s.col);
            end
          end
          default: kwrite = 1'b1;
        endcase
      end
    end

    // One memory access per cycle; keyboard before received data
    if (kwrite || (s.rx_pend && s.sc == TTC_SC_IDLE)) begin
      next_s.mem_we = 1'b1;
      next_s.mem_addr = s.cur;
      next_s.mem_wdata = kwrite ? c : s.rx_char;
      next_s.rx_pend = kwrite ? next_s.rx_pend : 1'b0;
      if (s.cur != LAST) begin
        next_s.cur = s.cur + 1'b1;
        next_s.col = (s.col == CW'(COLS - 1)) ? '0 : s.col + 1'b1;
      end
    end
    if (s.sc != TTC_SC_IDLE) begin
      next_s.rx_pend = 1'b0;
    end

    // Send key starts the block scan backward, or forward at position 0 when the cursor is there
    if (send_key_in && !lock && online && mode == TTC_MODE_BLOCK) begin
      next_s.sc = (s.cur == '0) ? TTC_SC_FRD : TTC_SC_BRD;
      next_s.pos = (s.cur == '0) ? '0 : s.cur - 1'b1;
    end

    // Memory scan; a break above may already have ended it
    if (next_s.sc != TTC_SC_IDLE || s.sc == TTC_SC_IDLE) begin
      case (s.sc)
        TTC_SC_BRD, TTC_SC_FRD: begin
          next_s.mem_rd = 1'b1;
          next_s.mem_addr = s.pos;
          next_s.sc = (s.sc == TTC_SC_BRD) ? TTC_SC_BW : TTC_SC_FW;
        end
        // Idle keeps a start requested above
        TTC_SC_IDLE: begin
        end
        TTC_SC_BW: next_s.sc = TTC_SC_BCHK;
        TTC_SC_FW: next_s.sc = TTC_SC_FCHK;
        TTC_SC_BCHK: begin
          if (mem_rdata_in == `TTC_CH_STX || s.pos == '0) begin
            next_s.sc = TTC_SC_FRD;
          end else begin
            next_s.pos = s.pos - 1'b1;
            next_s.sc = TTC_SC_BRD;
          end
        end
        TTC_SC_FCHK: begin
          next_s.sc_char = mem_rdata_in;
          next_s.sc = TTC_SC_SEND;
          next_s.sc_pgend = 1'b0;
          if (mode == TTC_MODE_LINE) begin
            next_s.sc_last = (mem_rdata_in == `TTC_CH_CR) || (s.pos == LAST);
          end else begin
            term = (s.cfg[`TTC_CFG_TERM_ETX] && mem_rdata_in == `TTC_CH_ETX) ||
                   (s.cfg[`TTC_CFG_TERM_EOT] && mem_rdata_in == `TTC_CH_EOT);
            next_s.sc_last = term || (s.pos == LAST);
            next_s.sc_pgend = ~term;
            if (term && !s.cfg[`TTC_CFG_SEND_TERM]) begin
              finish = 1'b1;
            end
          end
        end
        TTC_SC_SEND: begin
          if (take) begin
            if (s.sc_last) begin
              finish = 1'b1;
            end else begin
              next_s.pos = s.pos + 1'b1;
              next_s.sc = TTC_SC_FRD;
            end
          end
        end
        default: next_s.sc = TTC_SC_IDLE;
      endcase
    end
    if (finish) begin
      next_s.sc = TTC_SC_IDLE;
      if (mode == TTC_MODE_LINE) begin
        next_s.cur = s.sc_start;
        next_s.col = '0;
      end else if (next_s.sc_pgend && s.pos == LAST) begin
        next_s.cur = LAST;
        next_s.col = CW'(COLS - 1);
      end
    end

    // Register port
    if (reg_wr_in && reg_addr_in == `TTC_REG_CFG) begin
      next_s.cfg = reg_wdata_in[11:0];
    end
    if (reg_wr_in && reg_addr_in == `TTC_REG_STAT && reg_wdata_in[`TTC_STAT_PERR]) begin
      // New error in the clearing cycle wins
      next_s.perr = perr_new;
    end
    if (reg_rd_in && reg_addr_in == `TTC_REG_CFG) begin
      next_s.rdata = {20'h0_0000, s.cfg};
    end else if (reg_rd_in && reg_addr_in == `TTC_REG_STAT) begin
      next_s.rdata = {16'h0000, 6'h00, s.f_cnt, s.sc, s.perr, s.rx_busy, s.tx_busy, s.alert, s.lock_lamp};
      next_s.rdata[31:16] = 16'(s.cur);
    end

    next_s.lock_lamp = next_s.brk_lock | fmt | (next_s.sc != TTC_SC_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s <= '0;
      s.sw1 <= `TTC_SW_RESET;
      s.sw2 <= `TTC_SW_RESET;
      s.rx_prev <= 1'b1;
      s.sc <= TTC_SC_IDLE;
      s.cfg <= `TTC_CFG_RESET;
      s.txd <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign mem_addr_out = s.mem_addr;
  assign mem_wdata_out = s.mem_wdata;
  assign mem_we_out = s.mem_we;
  assign mem_rd_out = s.mem_rd;
  assign txd_out = s.txd;
  assign rts_out = s.rts;
  assign kbd_lock_lamp_out = s.lock_lamp;
  assign alert_lamp_out = s.alert;
  assign reg_rdata_out = s.rdata;
endmodule

// ---- verification/ttc_monitor.sv ----
// Concurrent checks on the terminal transmission control ports
`timescale 1ns/1ns
module ttc_monitor #(
  parameter int CLK_HZ = 25000000
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic online_in,
  input wire logic format_in,
  input wire logic rxd_in,
  input wire logic cts_in,
  input wire logic break_key_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic mem_rd_out,
  input wire logic txd_out,
  input wire logic rts_out,
  input wire logic kbd_lock_lamp_out,
  input wire logic alert_lamp_out,
  input wire logic [31:0] reg_rdata_out
);
  // Ten bit times at the slowest rate bound any mark run inside a frame
  localparam int IDLE_CYC = CLK_HZ / 110 * 10;
  localparam int BRK_CYC = CLK_HZ / 110 * 11;
  logic [31:0] hi_cnt;
  logic [31:0] lo_cnt;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hi_cnt <= 32'h0;
      lo_cnt <= 32'h0;
    end else begin
      hi_cnt <= txd_out ? hi_cnt + 32'h1 : 32'h0;
      lo_cnt <= rxd_in ? 32'h0 : lo_cnt + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence cts_gone;
    !cts_in [*8] ##0 hi_cnt >= IDLE_CYC;
  endsequence
  sequence brk_clear;
    rxd_in [*4] ##0 break_key_in ##1 rxd_in [*4];
  endsequence
  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data outside read cycle");
  unmapped_read_a: assert property (reg_rd_in && reg_addr_in == 4'h8 |=> reg_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  rts_follow_a: assert property (online_in [*5] |-> rts_out)
    else $error("request to send missing on line");
  local_rts_a: assert property (!online_in [*5] |-> !rts_out)
    else $error("request to send while local");
  format_lock_a: assert property (format_in [*5] |-> kbd_lock_lamp_out)
    else $error("format position without lock lamp");
  cts_hold_a: assert property (cts_gone |=> txd_out)
    else $error("frame started without clear to send");
  break_lamps_a: assert property (lo_cnt == BRK_CYC |-> alert_lamp_out && kbd_lock_lamp_out)
    else $error("break without alert and lock lamps");
  key_clear_a: assert property (brk_clear |-> !alert_lamp_out)
    else $error("alert lamp stays after break key");
  scan_lock_a: assert property (mem_rd_out |-> ##[0:1] kbd_lock_lamp_out)
    else $error("memory scan with keyboard unlocked");
endmodule
bind ttc_top ttc_monitor #(.CLK_HZ(CLK_HZ)) u_mon (
  .clk_in(clk_in),
  .reset_in(reset_in),
  .online_in(online_in),
  .format_in(format_in),
  .rxd_in(rxd_in),
  .cts_in(cts_in),
  .break_key_in(break_key_in),
  .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in),
  .mem_rd_out(mem_rd_out),
  .txd_out(txd_out),
  .rts_out(rts_out),
  .kbd_lock_lamp_out(kbd_lock_lamp_out),
  .alert_lamp_out(alert_lamp_out),
  .reg_rdata_out(reg_rdata_out)
);

// ---- verification/ttc_modem_model.sv ----
// Behavioural modem: frame decoder, break source, clear to send
`timescale 1ns/1ns
module ttc_modem_model (
  input wire logic clk_in,
  input wire logic txd_in,
  input wire logic [15:0] bit_cyc_in,
  output logic rxd_out,
  output logic cts_out
);
  logic [9:0] f;
  logic [9:0] rx_q[$];
  logic cts_ok = 1'b1;
  logic rxd_q = 1'b1;
  assign cts_out = cts_ok;
  assign rxd_out = rxd_q;
  ////////////////////////////////////////////////////////////////////////
  // Mid-bit sampling tolerates a one-cycle longer start bit
  always begin
    @(negedge txd_in);
    repeat (bit_cyc_in / 2) @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd_in;
      if (i < 9) begin
        repeat (bit_cyc_in) @(posedge clk_in);
      end
    end
    rx_q.push_back(f);
  end
  task automatic brk(input int n);
    @(posedge clk_in);
    rxd_q <= 1'b0;
    repeat (n) @(posedge clk_in);
    rxd_q <= 1'b1;
  endtask
endmodule

// ---- verification/tb_terminal_transmission_control.sv ----
// Self-checking bench for the terminal transmission control block
`timescale 1ns/1ns
`include "ttc_consts.svh"
module tb_terminal_transmission_control;
  import ttc_pkg::*;
  localparam int HZ = 96000;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic online = 1'b1, echo = 1'b0, c64 = 1'b0, fmt = 1'b0, rxd, cts;
  logic [1:0] rate = 2'h1, mode = 2'h0, par = 2'h0;
  logic stb = 1'b0, ctrl = 1'b0, send = 1'b0, brk_key = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [6:0] code = 7'h0, mem_rdata = 7'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] rdata;
  logic [10:0] mem_addr;
  logic [6:0] mem_wdata;
  logic mem_we, mem_rd, txd, rts, lock, alert;
  logic [15:0] bit_cyc = 16'd10;
  logic [6:0] mem [0:2047];
  logic [6:0] cs [3];
  logic [17:0] wq[$];
  logic [6:0] line_q[$];
  int miscompares = 0;
  int n_tests = 0;
  int cur = 0;
  logic mark_lvl = 1'b1;
  ttc_top #(.CLK_HZ(HZ)) DUT (.clk_in(clk_in), .reset_in(reset_in), .online_in(online),
    .echo_routing_select_in(echo), .char64_in(c64), .rate_select_in(rate), .mode_select_in(mode),
    .parity_select_in(par), .format_in(fmt), .rxd_in(rxd), .cts_in(cts), .kbd_strobe_in(stb),
    .kbd_code_in(code), .kbd_ctrl_in(ctrl), .send_key_in(send), .break_key_in(brk_key),
    .mem_rdata_in(mem_rdata), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_we_out(mem_we),
    .mem_rd_out(mem_rd), .txd_out(txd), .rts_out(rts), .kbd_lock_lamp_out(lock),
    .alert_lamp_out(alert), .reg_rdata_out(rdata));
  ttc_modem_model MDM (.clk_in(clk_in), .txd_in(txd), .bit_cyc_in(bit_cyc), .rxd_out(rxd), .cts_out(cts));
  always #20 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////
  // Unread cycles show inverted data so a stale sample never matches
  always @(posedge clk_in) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
      wq.push_back({mem_addr, mem_wdata});
    end
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic key(input logic [6:0] c);
    @(posedge clk_in);
    stb <= 1'b1;
    code <= c;
    @(posedge clk_in);
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic getf(input logic [6:0] c);
    logic pb;
    for (int i = 0; i < 20000 && MDM.rx_q.size() == 0; i++) begin
      @(posedge clk_in);
    end
    if (MDM.rx_q.size() == 0) begin
      miscompares++;
      conclude();
    end
    pb = par == TTC_PAR_EVEN ? ^c : par == TTC_PAR_ODD ? ~^c : mark_lvl;
    chk(32'(MDM.rx_q.pop_front()), {22'h0, 1'b1, pb, c, 1'b0});
  endtask
  // Model cursor advances one place per stored code
  task automatic mw(input logic [6:0] c);
    for (int i = 0; i < 200 && wq.size() == 0; i++) begin
      @(posedge clk_in);
    end
    if (wq.size() == 0) begin
      miscompares++;
      conclude();
    end
    chk(32'(wq.pop_front()), {14'h0, 11'(cur), c});
    line_q.push_back(c);
    cur++;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(15));
    tick(6);
    chk(32'({txd, rts, lock, alert}), 32'h8);
    tick(6);
    reset_in <= 1'b0;
    tick(4);
    rd(4'h0, {20'h0, `TTC_CFG_RESET});
    rd(4'h8, 32'h0);
    $display("test reset done");
    online <= 1'b0;
    tick(5);
    key(7'h41);
    mw(7'h41);
    tick(200);
    chk(32'(MDM.rx_q.size()), 32'h0);
    online <= 1'b1;
    $display("test local done");
    for (int p = 0; p < 3; p++) begin
      par <= 2'(p);
      tick(5);
      for (int k = 0; k < 3; k++) begin
        cs[k] = 7'($urandom_range(32'h5F, 32'h20));
        key(cs[k]);
      end
      for (int k = 0; k < 3; k++) begin
        mw(cs[k]);
        getf(cs[k]);
      end
    end
    $display("test half duplex done");
    echo <= 1'b1;
    tick(5);
    key(7'h42);
    getf(7'h42);
    tick(5);
    chk(32'(wq.size()), 32'h0);
    echo <= 1'b0;
    c64 <= 1'b1;
    tick(5);
    key(7'h61);
    mw(7'h41);
    getf(7'h41);
    key(7'h7E);
    tick(300);
    chk(32'(MDM.rx_q.size() + wq.size()), 32'h0);
    c64 <= 1'b0;
    $display("test duplex and 64 done");
    for (int r = 0; r < 2; r++) begin
      rate <= r == 0 ? TTC_RATE_CENTER : TTC_RATE_LOW;
      bit_cyc <= r == 0 ? 16'(HZ / 300) : 16'(HZ / 110);
      tick(5);
      key(7'h43);
      mw(7'h43);
      getf(7'h43);
    end
    rate <= TTC_RATE_HIGH;
    bit_cyc <= 16'(HZ / 9600);
    $display("test rates done");
    MDM.cts_ok <= 1'b0;
    tick(5);
    key(7'h44);
    mw(7'h44);
    tick(9000);
    chk(32'({txd, 8'(MDM.rx_q.size())}), 32'h100);
    MDM.cts_ok <= 1'b1;
    getf(7'h44);
    fmt <= 1'b1;
    tick(5);
    key(7'h45);
    tick(20);
    chk(32'({lock, 8'(wq.size())}), 32'h100);
    fmt <= 1'b0;
    tick(5);
    chk(32'(lock), 32'h0);
    $display("test cts and format done");
    mode <= TTC_MODE_LINE;
    tick(5);
    key(7'h48);
    mw(7'h48);
    key(`TTC_CH_CR);
    mw(`TTC_CH_CR);
    foreach (line_q[i]) begin
      getf(line_q[i]);
      if (i == 0) begin
        chk(32'(lock), 32'h1);
      end
    end
    line_q.delete();
    cur = 0;
    tick(5);
    key(7'h4A);
    mw(7'h4A);
    $display("test line done");
    MDM.brk(10000);
    tick(5);
    chk(32'({alert, lock}), 32'h3);
    @(posedge clk_in);
    brk_key <= 1'b1;
    @(posedge clk_in);
    brk_key <= 1'b0;
    tick(5);
    chk(32'({alert, lock}), 32'h0);
    $display("test break done");
    // Space parity level, terminator suppressed
    mode <= TTC_MODE_BLOCK;
    par <= TTC_PAR_NONE;
    mark_lvl = 1'b0;
    wr(4'h0, 32'h209);
    rd(4'h0, 32'h209);
    tick(5);
    key(`TTC_CH_STX);
    mw(`TTC_CH_STX);
    key(7'h4B);
    mw(7'h4B);
    key(`TTC_CH_ETX);
    mw(`TTC_CH_ETX);
    @(posedge clk_in);
    send <= 1'b1;
    @(posedge clk_in);
    send <= 1'b0;
    getf(`TTC_CH_STX);
    getf(7'h4B);
    tick(40);
    chk(32'(MDM.rx_q.size()), 32'h0);
    rd(4'h4, 32'h0004_0000);
    $display("test block done");
    conclude();
  end
endmodule
